// ### design/tie_defines.vh
// Register map, field layout and reset values of the timer interrupt-enable bank
`ifndef TIE_DEFINES_VH
`define TIE_DEFINES_VH

`define TIE_ADDR_W           8
`define TIE_OFF_IRQ_EN_CLR   8'h24
`define TIE_OFF_IRQ_EN_SET   8'h28
`define TIE_OFF_IRQ_FLAG     8'h2C
`define TIE_OFF_GUARD        8'h40
`define TIE_OFF_IRQ_STAT     8'h44
`define TIE_OFF_IRQ_MASK     8'h48

`define TIE_EN_W             20
`define TIE_EN_MASK          20'hFF80F
`define TIE_EN_RESET         20'h00000
`define TIE_CH_LSB           16
`define TIE_HARD_LSB         14
`define TIE_SOFT_B_BIT       13
`define TIE_SOFT_A_BIT       12
`define TIE_DEBUG_BIT        11
`define TIE_ERR_BIT          3
`define TIE_CYCLE_BIT        2
`define TIE_RETRIG_BIT       1
`define TIE_OVF_BIT          0

`define TIE_EVT_W            3
`define TIE_EVT_BAD_ADDR     0
`define TIE_EVT_GUARD_BLOCK  1
`define TIE_EVT_TIMER_IRQ    2
`define TIE_EVT_RESET        3'h0

`endif

// ### design/tie_w1_bank.v
// Bank of write-one-to-set and write-one-to-clear bits with a readback
`timescale 1ns/100ps
module tie_w1_bank #(
	parameter W           = 20,
	parameter [W-1:0] IMP = {W{1'b1}}
) (
	input  wire         pclk,
	input  wire         presetn,
	input  wire [W-1:0] set_ones,
	input  wire [W-1:0] clr_ones,
	output reg  [W-1:0] value
);
	// Bits outside IMP are not implemented and stay zero
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value <= {W{1'b0}};
		end else begin
			value <= ((value & ~clr_ones) | set_ones) & IMP;
		end
	end
endmodule // tie_w1_bank

// ### design/tie_irq_enable.v
// APB register bank holding the shared interrupt-enable mask of the control timer
`timescale 1ns/100ps
`include "tie_defines.vh"
module tie_irq_enable #(
	parameter EW = `TIE_EN_W
) (
	input  wire                     pclk,
	input  wire                     presetn,
	input  wire                     psel,
	input  wire                     penable,
	input  wire                     pwrite,
	input  wire [31:0]              paddr,
	input  wire [31:0]              pwdata,
	input  wire [3:0]               pstrb,
	output reg  [31:0]              prdata,
	output reg                      pready,
	output reg                      pslverr,
	input  wire [EW-1:0]            timer_flags,
	output reg                      timer_irq,
	output reg  [EW-1:0]            irq_enable,
	output reg                      block_irq
);
	wire [EW-1:0]      mask_value;
	reg  [EW-1:0]      flag_hold;
	reg                guard;
	reg  [`TIE_EVT_W-1:0] evt_stat;
	reg  [`TIE_EVT_W-1:0] evt_mask;
	reg  [EW-1:0]      next_set;
	reg  [EW-1:0]      next_clr;
	reg  [31:0]        next_rdata;
	reg                next_err;
	reg  [`TIE_EVT_W-1:0] evt_now;
	reg  [EW-1:0]      wr_bits;
	wire               setup;
	wire               do_wr;
	wire [7:0]         addr;
	wire               fire;

	// No wait state: answer in the first access cycle
	assign setup = psel & ~penable;
	assign do_wr = psel & penable & pwrite & pready;
	assign addr  = paddr[7:0];
	assign fire  = |(flag_hold & mask_value);

	always @* begin
		next_set   = {EW{1'b0}};
		next_clr   = {EW{1'b0}};
		next_rdata = 32'h00000000;
		next_err   = 1'b0;
		evt_now    = {`TIE_EVT_W{1'b0}};
		wr_bits    = pwdata[EW-1:0];
		if (setup) begin
			if (paddr[31:8] != 24'h000000) begin
				next_err = 1'b1;
			end else if (addr == `TIE_OFF_IRQ_EN_CLR || addr == `TIE_OFF_IRQ_EN_SET) begin
				next_rdata[EW-1:0] = mask_value;
			end else if (addr == `TIE_OFF_IRQ_FLAG) begin
				next_rdata[EW-1:0] = flag_hold;
			end else if (addr == `TIE_OFF_GUARD) begin
				next_rdata[0] = guard;
			end else if (addr == `TIE_OFF_IRQ_STAT) begin
				next_rdata[`TIE_EVT_W-1:0] = evt_stat;
			end else if (addr == `TIE_OFF_IRQ_MASK) begin
				next_rdata[`TIE_EVT_W-1:0] = evt_mask;
			end else begin
				next_err = 1'b1;
			end
			if (next_err) begin
				evt_now[`TIE_EVT_BAD_ADDR] = 1'b1;
			end
		end
		// Writes take effect at the access edge; a guarded write is dropped
		if (do_wr && !pslverr && pstrb != 4'h0) begin
			if (addr == `TIE_OFF_IRQ_EN_CLR) begin
				if (guard) begin
					evt_now[`TIE_EVT_GUARD_BLOCK] = 1'b1;
				end else begin
					next_clr = wr_bits;
				end
			end else if (addr == `TIE_OFF_IRQ_EN_SET) begin
				if (guard) begin
					evt_now[`TIE_EVT_GUARD_BLOCK] = 1'b1;
				end else begin
					next_set = wr_bits;
				end
			end
		end
		if (fire) begin
			evt_now[`TIE_EVT_TIMER_IRQ] = 1'b1;
		end
	end

	tie_w1_bank #(
		.W   (EW),
		.IMP (`TIE_EN_MASK)
	) u_mask (
		.pclk     (pclk),
		.presetn  (presetn),
		.set_ones (next_set),
		.clr_ones (next_clr),
		.value    (mask_value)
	);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata     <= 32'h00000000;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			flag_hold  <= `TIE_EN_RESET;
			guard      <= 1'b0;
			evt_stat   <= `TIE_EVT_RESET;
			evt_mask   <= `TIE_EVT_RESET;
			timer_irq  <= 1'b0;
			irq_enable <= `TIE_EN_RESET;
			block_irq  <= 1'b0;
		end else begin
			pready <= setup;
			if (setup) begin
				prdata  <= next_rdata;
				pslverr <= next_err;
			end else if (pready) begin
				pslverr <= 1'b0;
			end
			flag_hold  <= timer_flags & `TIE_EN_MASK;
			timer_irq  <= fire;
			irq_enable <= mask_value;
			// Set beats clear for events landing on the clearing write
			if (do_wr && !pslverr && addr == `TIE_OFF_IRQ_STAT && pstrb[0]) begin
				evt_stat <= (evt_stat & ~pwdata[`TIE_EVT_W-1:0]) | evt_now;
			end else begin
				evt_stat <= evt_stat | evt_now;
			end
			if (do_wr && !pslverr && pstrb[0]) begin
				if (addr == `TIE_OFF_GUARD) begin
					guard <= pwdata[0];
				end else if (addr == `TIE_OFF_IRQ_MASK) begin
					evt_mask <= pwdata[`TIE_EVT_W-1:0];
				end
			end
			block_irq <= |((evt_stat | evt_now) & evt_mask);
		end
	end
endmodule // tie_irq_enable

// ### tb/tie_irq_enable_chk.sv
// Checker for the timer interrupt-enable register bank
`timescale 1ns/100ps
module tie_irq_enable_chk (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0]  pstrb,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire [19:0] timer_flags,
	input wire        timer_irq,
	input wire [19:0] irq_enable
);
	localparam [19:0] M = 20'hFF80F;
	reg  guard;
	wire acc = psel && penable && pready;
	wire wr = acc && pwrite && |pstrb && !guard;
	wire en = paddr == 32'h24 || paddr == 32'h28;
	wire rde = acc && !pwrite && en;
	// Mirror of the write-protect bit
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			guard <= 1'b0;
		else if (acc && pwrite && paddr == 32'h40 && pstrb[0])
			guard <= pwdata[0];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_ans; pready ##1 !pready; endsequence
	property p_ans; psel && !penable |=> s_ans; endproperty
	a_ans: assert property (p_ans) else $error("no single answer cycle");
	property p_set; wr && paddr == 32'h28 |->
		##2 irq_enable == ($past(irq_enable, 2) | M & $past(pwdata[19:0], 2)); endproperty
	a_set: assert property (p_set) else $error("set write wrong");
	property p_clr; wr && paddr == 32'h24 |->
		##2 irq_enable == ($past(irq_enable, 2) & ~$past(pwdata[19:0], 2)); endproperty
	a_clr: assert property (p_clr) else $error("clear write wrong");
	property p_keep; !(wr && en) |-> ##2 irq_enable == $past(irq_enable); endproperty
	a_keep: assert property (p_keep) else $error("mask moved");
	property p_rd; rde |-> prdata == {12'h000, irq_enable}; endproperty
	a_rd: assert property (p_rd) else $error("readback wrong");
	property p_rsv; rde |-> prdata[31:20] == 12'h000 && prdata[10:4] == 7'h00; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
	property p_err; acc |-> pslverr == !(paddr[31:8] == 24'h000000
		&& paddr[7:0] inside {8'h24, 8'h28, 8'h2C, 8'h40, 8'h44, 8'h48}); endproperty
	a_err: assert property (p_err) else $error("error response wrong");
	property p_irq; timer_irq == |($past(timer_flags, 2) & irq_enable); endproperty
	a_irq: assert property (p_irq) else $error("timer irq wrong");
endmodule // tie_irq_enable_chk
bind tie_irq_enable tie_irq_enable_chk u_chk (.*);

// ### tb/tie_irq_enable_bench.sv
// Self-checking bench for the timer interrupt-enable register bank
`timescale 1ns/100ps
module tie_irq_enable_bench;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [19:0] timer_flags = 20'h0;
	logic [31:0] prdata, rd, ex;
	logic        pready, pslverr, timer_irq, block_irq, er;
	logic [19:0] irq_en;
	int          n_fail = 0;
	int          compares = 0;
	logic [19:0] pat [6] = '{20'hF0000, 20'hC000, 20'h2000, 20'h1800, 20'hC, 20'h3};
	tie_irq_enable dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timer_flags(timer_flags),
		.timer_irq(timer_irq), .irq_enable(irq_en), .block_irq(block_irq));
	initial forever #4 pclk = ~pclk;
	task chk(input logic [31:0] s, x);
		compares++;
		if (s !== x) begin
			n_fail++;
			$display("[ERR] %0t seen %h want %h", $time, s, x);
		end
	endtask
	task apb(input logic w, input logic [31:0] a, d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle cycle keeps back-to-back calls from driving psel twice
		@(posedge pclk);
	endtask
	task finish_test;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#100000;
		n_fail++;
		finish_test;
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 32'h28, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, 32'h28, 32'hFFFFFFFF);
		apb(1'b1, 32'h24, 32'h0);
		apb(1'b0, 32'h24, 32'h0);
		chk(rd, 32'hFF80F);
		chk({12'h000, irq_en}, 32'hFF80F);
		$display("set test done");
		ex = 32'hFF80F;
		foreach (pat[i]) begin
			ex &= ~{12'h000, pat[i]};
			apb(1'b1, 32'h24, {12'h000, pat[i]});
			apb(1'b0, 32'h28, 32'h0);
			chk(rd, ex);
		end
		$display("clear test done");
		apb(1'b1, 32'h28, 32'h1);
		apb(1'b1, 32'h40, 32'h1);
		apb(1'b1, 32'h28, 32'hFFFFF);
		apb(1'b1, 32'h24, 32'h1);
		apb(1'b0, 32'h24, 32'h0);
		chk(rd, 32'h1);
		chk({12'h000, irq_en}, 32'h1);
		apb(1'b0, 32'h44, 32'h0);
		chk(rd, 32'h2);
		apb(1'b1, 32'h40, 32'h0);
		$display("guard test done");
		apb(1'b1, 32'h28, 32'h1);
		timer_flags <= 20'h1;
		repeat (4) @(posedge pclk);
		chk(timer_irq, 1'b1);
		apb(1'b1, 32'h24, 32'h1);
		@(posedge pclk);
		chk(timer_irq, 1'b0);
		timer_flags <= 20'h0;
		$display("irq test done");
		apb(1'b0, 32'h100, 32'h0);
		chk(er, 1'b1);
		apb(1'b1, 32'h48, 32'h1);
		@(posedge pclk);
		chk(block_irq, 1'b1);
		apb(1'b1, 32'h44, 32'h1);
		@(posedge pclk);
		chk(block_irq, 1'b0);
		$display("event test done");
		apb(1'b1, 32'h28, 32'hFF80F);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 32'h28, 32'h0);
		chk(rd, 32'h0);
		chk(block_irq, 1'b0);
		$display("reset test done");
		finish_test;
	end
endmodule // tie_irq_enable_bench
